// ---- core/aic_top.sv ----
// Amplifier control port: bus target, instruction decode, diagnostics.
// Assumes bus pins and straps are asynchronous to ref_clk and that the
// bus clock runs at most one eighth of ref_clk.
//
// What the document requires of this block and its host
// RULE_01: Host sequences power-up with documented waits.
// RULE_02: Host mutes, waits, then asserts hardware standby.
// RULE_03: Host enables diagnostics, waits, reads until clean.
// RULE_04: Open strap disables bus; standby/mute pin controls.
// RULE_05: Bus disabled: data pin selects gain.
// RULE_06: Strap picks one of three addresses.
// RULE_07: Data changes only while clock low.
// RULE_08: Start and stop are data edges, clock high.
// RULE_09: Eight bits, MSB first, then acknowledge.
// RULE_10: Receiver pulls data low during acknowledge.
// RULE_11: Address: fixed bits, selector bits, direction bit.
// RULE_12: Write carries instruction byte one, then two.
// RULE_13: Read returns diagnostic bytes one to four.
// RULE_14: Byte one: mute threshold, diagnostics, offset enable.
// RULE_15: Byte one: front and rear gain select.
// RULE_16: Byte one: front/rear unmute, clip threshold.
// RULE_17: Byte two: fast mute, current threshold.
// RULE_18: Byte two bit four releases standby.
// RULE_19: Byte two: line-driver, current diagnostics, safety routine.
// RULE_20: Diagnostic byte one: thermal warning, cycle done.
// RULE_21: Open-load flag follows selected current threshold.
// RULE_22: Channel one fault field layout.
// RULE_23: Each read restarts cycles, returns previous results.
// RULE_24: Offset must persist between reads to flag.
// RULE_25: Diagnostic byte two: offset status, channel two.
// RULE_26: Apply instructions at stop; ignore extra bytes.
module aic_top
	import aic_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Bus pins, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Straps and hardware control pins
	input wire logic [1:0] address_select_pin,
	input wire logic standby_mute_pin,
	// Live status from the analog side
	input wire logic thermal_warn,
	input wire logic cycle_done,
	input wire logic offset_active,
	input wire logic ssr_offset_mute,
	input wire logic [4*aic_pkg::AIC_CH_BITS-1:0] chan_flags,
	input wire logic [3:0] chan_offset_raw,
	// Decoded amplifier controls
	output logic bus_enabled,
	output logic supply_mute_thr_high,
	output logic diag_en,
	output logic offset_det_en,
	output logic front_gain_16db,
	output logic rear_gain_16db,
	output logic front_unmute,
	output logic rear_unmute,
	output logic clip_thr_10pct,
	output logic cur_thr_low,
	output logic fast_mute,
	output logic amp_run,
	output logic line_driver_diag,
	output logic cur_diag_en,
	output logic ssr_en,
	// Start of a new diagnostic cycle, one-cycle pulse
	output logic diag_restart
);
	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	aic_sync #(.W(5)) u_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.din({standby_mute_pin, address_select_pin, sda_in, scl_in}),
		.dout(pins_s)
	);

	// Named views of the synchronised pins
	wire scl_s = pins_s[0];
	wire sda_s = pins_s[1];
	wire [1:0] strap_s = pins_s[3:2];
	wire stbmute_s = pins_s[4];

	// Previous samples for edge finding
	logic scl_d_r;
	logic sda_d_r;

	// Bus conditions, each a one-cycle strobe
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s; // [RULE_08]
	wire stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s; // [RULE_08]

	// Open strap turns the bus off entirely
	wire legacy = (strap_s == AIC_STRAP_OPEN); // [RULE_04]

	// ----------------------------------------------------------------
	// Engine state
	// ----------------------------------------------------------------
	aic_state_e state_r;
	aic_state_e state_nxt;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [1:0] byte_idx_r;
	logic [1:0] byte_idx_nxt;
	logic rd_dir_r;
	logic rd_dir_nxt;
	// High while this end pulls the data line down
	logic drive_low_r;
	logic drive_low_nxt;
	// Instruction bytes in flight and applied
	logic [7:0] ib1_tmp_r;
	logic [7:0] ib2_tmp_r;
	logic [7:0] ib1_r;
	logic [7:0] ib2_r;
	logic [1:0] wr_cnt_r;
	logic [1:0] wr_cnt_nxt;
	logic read_start_nxt;

	// Diagnostic bytes captured at read start
	logic [31:0] db_flat;

	// Address match: fixed field plus strap-selected bits
	wire [7:0] addr_byte = {shift_r[6:0], sda_s};
	wire addr_hit = (addr_byte[7:3] == AIC_ADDR_FIXED) // [RULE_11]
		& (addr_byte[2:1] == strap_s) & ~legacy; // [RULE_06]

	// Byte being sent, chosen by index
	wire [7:0] tx_byte = db_flat[byte_idx_r*8 +: 8]; // [RULE_13]

	// Eighth bit of a byte arrives on this rise
	wire last_bit = (bit_cnt_r == 4'(AIC_BITS_PER_BYTE - 1));

	// ----------------------------------------------------------------
	// Next-state logic of the bus engine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		byte_idx_nxt = byte_idx_r;
		rd_dir_nxt = rd_dir_r;
		drive_low_nxt = drive_low_r;
		wr_cnt_nxt = wr_cnt_r;
		read_start_nxt = 1'b0;
		case (state_r)
			AIC_IDLE: begin
				drive_low_nxt = 1'b0;
			end
			// Collect address, MSB first
			AIC_ADDR: begin
				if (scl_rise) begin
					shift_nxt = addr_byte; // [RULE_09]
					bit_cnt_nxt = bit_cnt_r + 4'h1;
					if (last_bit) begin
						rd_dir_nxt = sda_s; // [RULE_11]
						state_nxt = addr_hit ? AIC_ADDR_ACK : AIC_IDLE;
					end
				end
			end
			// Pull low on the fall; the next fall releases, or drives the first read bit
			AIC_ADDR_ACK: begin
				if (scl_fall) begin
					if (!drive_low_r) begin
						drive_low_nxt = 1'b1; // [RULE_10]
						// Snapshot loads under the ack, ready by its end
						read_start_nxt = rd_dir_r; // [RULE_23]
					end else begin
						bit_cnt_nxt = 4'h0;
						byte_idx_nxt = 2'h0;
						wr_cnt_nxt = 2'h0;
						if (rd_dir_r) begin
							// First bit goes out on the fall ending the ack
							bit_cnt_nxt = 4'h1;
							drive_low_nxt = ~db_flat[7]; // [RULE_13]
							state_nxt = AIC_RD_BYTE;
						end else begin
							drive_low_nxt = 1'b0; // [RULE_07]
							state_nxt = AIC_WR_BYTE;
						end
					end
				end
			end
			// Collect instruction byte
			AIC_WR_BYTE: begin
				if (scl_rise) begin
					shift_nxt = addr_byte; // [RULE_09]
					bit_cnt_nxt = bit_cnt_r + 4'h1;
					if (last_bit) begin
						state_nxt = AIC_WR_ACK;
						if (wr_cnt_r != AIC_WR_BYTES) begin
							wr_cnt_nxt = wr_cnt_r + 2'h1; // [RULE_12]
						end
					end
				end
			end
			// Acknowledge every written byte
			AIC_WR_ACK: begin
				if (scl_fall) begin
					if (!drive_low_r) begin
						drive_low_nxt = 1'b1; // [RULE_10]
					end else begin
						drive_low_nxt = 1'b0;
						bit_cnt_nxt = 4'h0;
						state_nxt = AIC_WR_BYTE;
					end
				end
			end
			// Shift out diagnostic bits on each fall
			AIC_RD_BYTE: begin
				if (scl_fall) begin
					if (bit_cnt_r == 4'(AIC_BITS_PER_BYTE)) begin
						drive_low_nxt = 1'b0; // [RULE_10]
						state_nxt = AIC_RD_ACK;
						byte_idx_nxt = byte_idx_r + 2'h1;
					end else begin
						drive_low_nxt = ~tx_byte[3'(7 - bit_cnt_r)]; // [RULE_07]
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end
				end
			end
			// Host acknowledge; no ack ends the read
			AIC_RD_ACK: begin
				if (scl_rise && sda_s) begin
					state_nxt = AIC_IDLE;
				end else if (scl_fall) begin
					bit_cnt_nxt = 4'h1;
					drive_low_nxt = ~tx_byte[7]; // [RULE_09]
					state_nxt = AIC_RD_BYTE;
				end
			end
			default: begin
				state_nxt = AIC_IDLE;
				drive_low_nxt = 1'b0;
			end
		endcase
		// Start and stop override any byte in progress
		if (start_cond && !legacy) begin
			state_nxt = AIC_ADDR;
			bit_cnt_nxt = 4'h0;
			// A refused address must not reapply an old write at stop
			wr_cnt_nxt = 2'h0;
			drive_low_nxt = 1'b0;
		end else if (stop_cond || legacy) begin
			state_nxt = AIC_IDLE;
			drive_low_nxt = 1'b0;
		end
	end

	// Write the just-completed byte into its slot, extras dropped
	wire wr_done = (state_r == AIC_WR_BYTE) & scl_rise & last_bit;
	wire take_ib1 = wr_done & (wr_cnt_r == 2'h0); // [RULE_12]
	wire take_ib2 = wr_done & (wr_cnt_r == 2'h1); // [RULE_26]
	// Both bytes seen and the transfer closed by stop
	wire apply_ib = stop_cond & ~rd_dir_r & (wr_cnt_r == AIC_WR_BYTES);

	// ----------------------------------------------------------------
	// Engine registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			state_r <= AIC_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			byte_idx_r <= 2'h0;
			rd_dir_r <= 1'b0;
			drive_low_r <= 1'b0;
			wr_cnt_r <= 2'h0;
			diag_restart <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			byte_idx_r <= byte_idx_nxt;
			rd_dir_r <= rd_dir_nxt;
			drive_low_r <= drive_low_nxt;
			wr_cnt_r <= wr_cnt_nxt;
			diag_restart <= read_start_nxt; // [RULE_23]
		end
	end

	// ----------------------------------------------------------------
	// Instruction bytes: staged while received, applied at stop
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ib1_tmp_r <= AIC_IB1_RESET;
			ib2_tmp_r <= AIC_IB2_RESET;
			ib1_r <= AIC_IB1_RESET;
			ib2_r <= AIC_IB2_RESET;
		end else begin
			if (take_ib1) begin
				ib1_tmp_r <= addr_byte;
			end
			if (take_ib2) begin
				ib2_tmp_r <= addr_byte;
			end
			if (apply_ib) begin
				ib1_r <= ib1_tmp_r; // [RULE_26]
				ib2_r <= ib2_tmp_r; // [RULE_26]
			end
		end
	end

	// ----------------------------------------------------------------
	// Diagnostic store
	// ----------------------------------------------------------------
	aic_diag u_diag (
		.ref_clk(ref_clk),
		.srst(srst),
		.read_start(read_start_nxt),
		.offset_en(offset_det_en),
		.thermal_warn(thermal_warn),
		.cycle_done(cycle_done),
		.offset_active(offset_active),
		.ssr_offset_mute(ssr_offset_mute),
		.standby_stat(ib2_r[AIC_IB2_RUN]),
		.diag_stat(ib1_r[AIC_IB1_DIAG_EN]),
		.chan_flags(chan_flags),
		.chan_offset_raw(chan_offset_raw),
		.db_flat(db_flat)
	);

	// ----------------------------------------------------------------
	// Control outputs; legacy mode takes gains, unmutes and run from pins instead
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			bus_enabled <= 1'b0;
			supply_mute_thr_high <= 1'b0;
			diag_en <= 1'b0;
			offset_det_en <= 1'b0;
			front_gain_16db <= 1'b0;
			rear_gain_16db <= 1'b0;
			front_unmute <= 1'b0;
			rear_unmute <= 1'b0;
			clip_thr_10pct <= 1'b0;
			cur_thr_low <= 1'b0;
			fast_mute <= 1'b0;
			amp_run <= 1'b0;
			line_driver_diag <= 1'b0;
			cur_diag_en <= 1'b0;
			ssr_en <= 1'b0;
		end else begin
			// Open drain: only ever pulls low
			sda_out <= 1'b0;
			sda_oe_n <= ~drive_low_nxt | legacy; // [RULE_10]
			bus_enabled <= ~legacy; // [RULE_04]
			supply_mute_thr_high <= ib1_r[AIC_IB1_MUTE_THR]; // [RULE_14]
			diag_en <= ib1_r[AIC_IB1_DIAG_EN]; // [RULE_14]
			offset_det_en <= ib1_r[AIC_IB1_OFS_EN]; // [RULE_14]
			clip_thr_10pct <= ib1_r[AIC_IB1_CLIP]; // [RULE_16]
			cur_thr_low <= ib2_r[AIC_IB2_CUR_THR]; // [RULE_17] [RULE_21]
			fast_mute <= ib2_r[AIC_IB2_FAST_MUTE]; // [RULE_17]
			line_driver_diag <= ib2_r[AIC_IB2_LINE_DRV]; // [RULE_19]
			cur_diag_en <= ib2_r[AIC_IB2_CUR_DIAG]; // [RULE_19]
			ssr_en <= ib2_r[AIC_IB2_SSR]; // [RULE_19]
			if (legacy) begin
				front_gain_16db <= sda_s; // [RULE_05]
				rear_gain_16db <= sda_s; // [RULE_05]
				front_unmute <= stbmute_s; // [RULE_04]
				rear_unmute <= stbmute_s; // [RULE_04]
				amp_run <= stbmute_s; // [RULE_04]
			end else begin
				front_gain_16db <= ib1_r[AIC_IB1_FGAIN]; // [RULE_15]
				rear_gain_16db <= ib1_r[AIC_IB1_RGAIN]; // [RULE_15]
				front_unmute <= ib1_r[AIC_IB1_FUNMUTE]; // [RULE_16]
				rear_unmute <= ib1_r[AIC_IB1_RUNMUTE]; // [RULE_16]
				amp_run <= ib2_r[AIC_IB2_RUN]; // [RULE_18]
			end
		end
	end
endmodule // aic_top

// ---- common/aic_pkg.sv ----
// Constants, field layouts and state types for the amplifier control port.
// Assumes the strap level arrives already resolved into a two-bit code.
package aic_pkg;

	// ----------------------------------------------------------------
	// Target address
	// ----------------------------------------------------------------
	// Fixed upper five address bits, then two strap-driven selector bits
	localparam logic [4:0] AIC_ADDR_FIXED = 5'h1B;
	// Strap codes: three bus addresses, one open pin for legacy mode
	localparam logic [1:0] AIC_STRAP_SEL0 = 2'h0;
	localparam logic [1:0] AIC_STRAP_SEL1 = 2'h1;
	localparam logic [1:0] AIC_STRAP_SEL2 = 2'h2;
	localparam logic [1:0] AIC_STRAP_OPEN = 2'h3;

	// ----------------------------------------------------------------
	// Transfer shape
	// ----------------------------------------------------------------
	localparam int AIC_BITS_PER_BYTE = 8;
	localparam logic [1:0] AIC_WR_BYTES = 2'h2;
	localparam logic [1:0] AIC_RD_LAST = 2'h3;

	// ----------------------------------------------------------------
	// Instruction byte one fields
	// ----------------------------------------------------------------
	localparam int AIC_IB1_MUTE_THR = 7;
	localparam int AIC_IB1_DIAG_EN = 6;
	localparam int AIC_IB1_OFS_EN = 5;
	localparam int AIC_IB1_FGAIN = 4;
	localparam int AIC_IB1_RGAIN = 3;
	localparam int AIC_IB1_FUNMUTE = 2;
	localparam int AIC_IB1_RUNMUTE = 1;
	localparam int AIC_IB1_CLIP = 0;
	localparam logic [7:0] AIC_IB1_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Instruction byte two fields
	// ----------------------------------------------------------------
	localparam int AIC_IB2_CUR_THR = 7;
	localparam int AIC_IB2_FAST_MUTE = 5;
	localparam int AIC_IB2_RUN = 4;
	localparam int AIC_IB2_LINE_DRV = 3;
	localparam int AIC_IB2_CUR_DIAG = 2;
	localparam int AIC_IB2_SSR = 0;
	localparam logic [7:0] AIC_IB2_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Diagnostic byte fields
	// ----------------------------------------------------------------
	localparam int AIC_CH_BITS = 6;
	localparam int AIC_CH_OPEN_OR_OFS = 2;
	localparam int AIC_DB1_THERMAL = 7;
	localparam int AIC_DB1_CYCLE_DONE = 6;
	localparam int AIC_DB2_OFS_ACTIVE = 7;
	localparam int AIC_DB2_SSR_MUTE = 6;
	localparam int AIC_DB3_STANDBY = 7;
	localparam int AIC_DB3_DIAG = 6;
	localparam logic [31:0] AIC_DB_RESET = 32'h0000_0000;

	// Bus engine states
	typedef enum logic [2:0] {
		AIC_IDLE, AIC_ADDR, AIC_ADDR_ACK, AIC_WR_BYTE, AIC_WR_ACK,
		AIC_RD_BYTE, AIC_RD_ACK
	} aic_state_e;

endpackage

// ---- core/aic_sync.sv ----
// Two-stage synchroniser for a group of unrelated pin levels.
// Assumes each bit is a slow level; no bus coherence is implied.
module aic_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Pin side and synchronised side
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// First stage is read only by the second stage
	logic [W-1:0] meta_r;

	// ----------------------------------------------------------------
	// Two flip-flops, reset to zero
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule // aic_sync

// ---- core/aic_diag.sv ----
// Diagnostic result store: live flags in, one-cycle-late snapshot out.
// Assumes read_start is a one-cycle pulse on ref_clk per read transfer.
module aic_diag
	import aic_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Control
	input wire logic read_start,
	input wire logic offset_en,
	// Live status from the analog side; standby and diagnostic status from the instruction bytes
	input wire logic thermal_warn,
	input wire logic cycle_done,
	input wire logic offset_active,
	input wire logic ssr_offset_mute,
	input wire logic standby_stat,
	input wire logic diag_stat,
	input wire logic [4*aic_pkg::AIC_CH_BITS-1:0] chan_flags,
	input wire logic [3:0] chan_offset_raw,
	// Bytes one to four, byte one in the low eight bits
	output logic [31:0] db_flat
);
	// Offset enable seen last cycle, for its rising edge
	logic ofs_en_d_r;
	// Offset seen on every cycle since the window opened
	logic [3:0] persist_r;
	logic [3:0] persist_nxt;
	// Results of the cycle that is still running
	logic [31:0] result_r;
	// Live byte image and per-channel fields
	logic [31:0] live;
	logic [4*AIC_CH_BITS-1:0] ch_field;
	wire ofs_start = read_start | (offset_en & ~ofs_en_d_r);

	// ----------------------------------------------------------------
	// Per-channel field: offset folds into the open/offset bit
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 4; c++) begin : g_ch
			wire ofs_hit = offset_en & persist_r[c] & chan_offset_raw[c];
			// One driver per field slice keeps the slices independent
			assign ch_field[c*AIC_CH_BITS +: AIC_CH_BITS] =
				chan_flags[c*AIC_CH_BITS +: AIC_CH_BITS]
				| (AIC_CH_BITS'(ofs_hit) << AIC_CH_OPEN_OR_OFS); // [RULE_24]
		end
	endgenerate

	// Offset must hold on every cycle of the window to count
	assign persist_nxt = ofs_start ? 4'hF : (persist_r & chan_offset_raw);

	// ----------------------------------------------------------------
	// Byte image; byte four carries channel four with top bits zero
	// ----------------------------------------------------------------
	always_comb begin
		live = '0;
		live[5:0] = ch_field[5:0]; // [RULE_22]
		live[AIC_DB1_THERMAL] = thermal_warn; // [RULE_20]
		live[AIC_DB1_CYCLE_DONE] = cycle_done; // [RULE_20]
		live[13:8] = ch_field[11:6]; // [RULE_25]
		live[8 + AIC_DB2_OFS_ACTIVE] = offset_active; // [RULE_25]
		live[8 + AIC_DB2_SSR_MUTE] = ssr_offset_mute; // [RULE_25]
		live[21:16] = ch_field[17:12];
		live[16 + AIC_DB3_STANDBY] = standby_stat;
		live[16 + AIC_DB3_DIAG] = diag_stat;
		live[29:24] = ch_field[23:18];
	end

	// ----------------------------------------------------------------
	// A read hands out the previous cycle and starts a new one
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ofs_en_d_r <= 1'b0;
			persist_r <= 4'h0;
			result_r <= AIC_DB_RESET;
			db_flat <= AIC_DB_RESET;
		end else begin
			ofs_en_d_r <= offset_en;
			persist_r <= persist_nxt;
			if (read_start) begin
				db_flat <= result_r; // [RULE_23]
				result_r <= live; // [RULE_23]
			end
		end
	end
endmodule // aic_diag

// ---- sim/aic_top_properties.sv ----
// Port-level checker for aic_top, bound into every instance.
// Assumes the bus clock stays low at least four ref_clk cycles.
module aic_top_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Bus and strap pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe_n,
	input wire logic [1:0] address_select_pin,
	input wire logic standby_mute_pin,
	// Decoded outputs
	input wire logic bus_enabled,
	input wire logic front_gain_16db,
	input wire logic rear_gain_16db,
	input wire logic amp_run,
	input wire logic diag_restart
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ------------------------------------------------------------
	// Strap handling: five cycles covers the pin synchroniser
	// ------------------------------------------------------------
	a_legacy_bus_off: assert property ((address_select_pin == 2'h3)[*4]
		|=> !bus_enabled) else $error("bus left on with open strap");
	a_strap_bus_on: assert property ((address_select_pin != 2'h3)[*4]
		|=> bus_enabled) else $error("bus off with strapped address");
	a_legacy_gain_pin: assert property ((address_select_pin == 2'h3
		&& $stable(sda_in))[*5] |-> front_gain_16db == sda_in
		&& rear_gain_16db == sda_in) else $error("legacy gain wrong");
	a_legacy_run_pin: assert property ((address_select_pin == 2'h3
		&& $stable(standby_mute_pin))[*5] |-> amp_run == standby_mute_pin)
		else $error("legacy run wrong");
	a_quiet_when_off: assert property (!bus_enabled |-> sda_oe_n)
		else $error("data driven with bus off");
	// ------------------------------------------------------------
	// Wire behaviour and transfer side effects
	// ------------------------------------------------------------
	a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data drive changed with clock high");
	a_drive_holds_low: assert property ($fell(sda_oe_n) |-> (!sda_oe_n)[*6])
		else $error("pull-down released early");
	a_apply_at_stop: assert property ($changed(amp_run) && bus_enabled
		&& address_select_pin != 2'h3 |-> scl_in && sda_in)
		else $error("controls changed outside stop");
	a_restart_pulse: assert property (diag_restart |-> bus_enabled
		##1 !diag_restart) else $error("restart not a single pulse");
	// Main scenarios reached
	c_restart: cover property (diag_restart);
	c_run: cover property ($rose(amp_run));
	c_legacy_run: cover property (!bus_enabled && amp_run);
endmodule // aic_top_properties

bind aic_top aic_top_properties aic_top_properties_inst (
	.ref_clk(ref_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
	.standby_mute_pin(standby_mute_pin), .bus_enabled(bus_enabled),
	.front_gain_16db(front_gain_16db), .rear_gain_16db(rear_gain_16db),
	.amp_run(amp_run), .diag_restart(diag_restart));

// ---- sim/aic_host.sv ----
// Bus master model: clock at 8 ref_clk cycles a bit, open-drain data.
// Assumes an external pull-up resolves the data wire when released.
module aic_host (
	// Timing reference
	input wire logic ref_clk,
	// Bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bus idles with clock high and data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Data moves only mid-low; sampled mid-high
	task automatic bit_xfer(input logic b, output logic s);
		tick(2);
		sda_low = !b;
		tick(2);
		scl = 1'b1;
		tick(2);
		s = sda;
		tick(2);
		scl = 1'b0;
	endtask
	// Falling data under high clock
	task automatic start_cond();
		sda_low = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask
	// Rising data under high clock, then idle long enough to apply
	task automatic stop_cond();
		tick(2);
		sda_low = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(8);
	endtask
	// Eight bits MSB first, then released ack slot
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic x;
		for (int i = 7; i >= 0; i--) bit_xfer(d[i], x);
		bit_xfer(1'b1, x);
		ack = !x;
	endtask
	// Host acks all but the last byte read
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic x;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
		bit_xfer(last, x);
	endtask
	// Legacy mode: data pin held as a static gain level
	task automatic hold_sda(input logic b);
		sda_low = !b;
	endtask
endmodule // aic_host

// ---- sim/aic_top_tb_top.sv ----
// Self-checking bench for aic_top driven through aic_host.
// Assumes inputs change on falling ref_clk edges only.
module aic_top_tb_top import aic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, srst, host_low, scl, sda, standby_mute_pin, ack;
	logic thermal_warn, cycle_done, offset_active, ssr_offset_mute;
	logic sda_out, sda_oe_n, bus_enabled, diag_restart;
	logic [1:0] address_select_pin;
	logic [23:0] chan_flags, f, p1 = 24'hFF_A55A, p2 = 24'hBD_2994;
	logic [7:0] ib1_seen;
	logic [5:0] ib2_seen;
	logic [31:0] rd, db_exp;
	int miscompares, check_count, restarts;
	// Wire-AND of both pull-downs against the pull-up
	assign sda = !(host_low || (!sda_oe_n && !sda_out));
	aic_top aic_top_inst (.ref_clk(ref_clk), .srst(srst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.address_select_pin(address_select_pin),
		.standby_mute_pin(standby_mute_pin), .thermal_warn(thermal_warn),
		.cycle_done(cycle_done), .offset_active(offset_active),
		.ssr_offset_mute(ssr_offset_mute), .chan_flags(chan_flags),
		.chan_offset_raw(4'h1), .bus_enabled(bus_enabled),
		.supply_mute_thr_high(ib1_seen[7]), .diag_en(ib1_seen[6]),
		.offset_det_en(ib1_seen[5]), .front_gain_16db(ib1_seen[4]),
		.rear_gain_16db(ib1_seen[3]), .front_unmute(ib1_seen[2]),
		.rear_unmute(ib1_seen[1]), .clip_thr_10pct(ib1_seen[0]),
		.cur_thr_low(ib2_seen[5]), .fast_mute(ib2_seen[4]),
		.amp_run(ib2_seen[3]), .line_driver_diag(ib2_seen[2]),
		.cur_diag_en(ib2_seen[1]), .ssr_en(ib2_seen[0]),
		.diag_restart(diag_restart));
	aic_host aic_host_inst (.ref_clk(ref_clk), .scl(scl),
		.sda_low(host_low), .sda(sda));
	// ------------------------------------------------------------
	// Clock, restart counter, watchdog
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (diag_restart === 1'b1) restarts++;
	initial begin
		#2000000;
		miscompares++;
		end_of_test();
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] sel, input logic [7:0] b1, b2,
		input int n, input logic exp_ack);
		aic_host_inst.start_cond();
		aic_host_inst.wbyte({AIC_ADDR_FIXED, sel, 1'b0}, ack);
		check(ack, exp_ack);
		if (n > 0) aic_host_inst.wbyte(b1, ack);
		if (n > 1) aic_host_inst.wbyte(b2, ack);
		if (n > 2) aic_host_inst.wbyte(~b1, ack);
		aic_host_inst.stop_cond();
	endtask
	task automatic check_ctl(input logic [7:0] b1, b2);
		check(ib1_seen, b1);
		check(ib2_seen, {b2[7], b2[5:2], b2[0]});
	endtask
	// Four bytes, byte one in the low eight bits, last one refused
	task automatic rd4(output logic [31:0] d);
		aic_host_inst.start_cond();
		aic_host_inst.wbyte({AIC_ADDR_FIXED, 2'h2, 1'b1}, ack);
		for (int i = 0; i < 4; i++) aic_host_inst.rbyte(i == 3, d[i*8+:8]);
		aic_host_inst.stop_cond();
	endtask
	task automatic end_of_test();
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		srst = 1'b1;
		address_select_pin = AIC_STRAP_SEL0;
		standby_mute_pin = 1'b0;
		{thermal_warn, cycle_done, offset_active, ssr_offset_mute} = 4'h0;
		chan_flags = 24'h00_0000;
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		repeat (6) @(negedge ref_clk);
		check_ctl(8'h00, 8'h00);
		// Every strap address, with its own instruction pattern
		for (int s = 0; s < 3; s++) begin
			address_select_pin = s[1:0];
			repeat (6) @(negedge ref_clk);
			wr(s[1:0], p1[(2-s)*8+:8], p2[(2-s)*8+:8], 2, 1'b1);
			check_ctl(p1[(2-s)*8+:8], p2[(2-s)*8+:8]);
		end
		// Wrong selector and a short write both leave controls alone
		wr(2'h1, 8'h00, 8'h00, 2, 1'b0);
		wr(2'h2, 8'h00, 8'h00, 1, 1'b1);
		check_ctl(8'h5A, 8'h94);
		// A third byte is discarded
		wr(2'h2, 8'h6E, 8'h9D, 3, 1'b1);
		check_ctl(8'h6E, 8'h9D);
		// Results lag one read behind; repeated reads as at install
		{thermal_warn, cycle_done, offset_active} = 3'h7;
		f = 24'h8A_51C7;
		chan_flags = f;
		rd4(rd);
		check(rd, 32'h0000_0000);
		db_exp = {2'b00, f[23:18], 2'b11, f[17:12], 2'b10, f[11:6], 2'b11, f[5:0]};
		rd4(rd);
		check(rd, db_exp);
		chan_flags = 24'h15_AE38;
		thermal_warn = 1'b0;
		rd4(rd);
		check(rd, db_exp);
		f = chan_flags;
		db_exp = {2'b00, f[23:18], 2'b11, f[17:12], 2'b10, f[11:6], 2'b01,
			f[5:0] | 6'h04};
		rd4(rd);
		check(rd, db_exp);
		check(restarts, 4);
		// Open strap: bus ignored, pins take over
		address_select_pin = AIC_STRAP_OPEN;
		repeat (6) @(negedge ref_clk);
		check(bus_enabled, 1'b0);
		wr(2'h2, 8'h00, 8'h00, 2, 1'b0);
		for (int v = 0; v < 2; v++) begin
			standby_mute_pin = v[0];
			aic_host_inst.hold_sda(v[0]);
			repeat (8) @(negedge ref_clk);
			check({ib1_seen[4:1], ib2_seen[3]}, {5{v[0]}});
		end
		end_of_test();
	end
endmodule // aic_top_tb_top
